// ---- common/tcpc_pkg.sv ----
// Package for the Type-C port mode and VCONN control block.
// Assumes a single 250 MHz clock and analog front ends that report CC
// termination, supply, VBUS and overcurrent as clean synchronous levels.
// Function
// - Source VCONN only as source, in attached source state, with Ra on other CC.
// - Stop VCONN on detach once the active cable is gone.
// - Host control: overcurrent sets fault flag, switch off until flag cleared.
// - Pin control: overcurrent turns switch off until detach then re-attach.
// - Sample three-level select pin; floating selects pin control, no bus access.
// - Select high sets target address bit 6 one, low sets it zero.
// - Pin control: current outputs HH/HL default, LH medium, LL high.
// - Pin control: shared output driven low while audio accessory attached.
// - Host control: interrupt output low when status is updated.
// - Interrupt sets a status indication that host clears by write.
// - VBUS sense decides sink attach/detach, accessories and dual-role result.
// - Start in unattached sink, read port pin, toggle roles if dual-role.
// - Unattached with supply: I/O operational, VCONN off.
// - Active: source signals on ID output, sink on current outputs in pin control.
// - Leave active on unplug, VBUS loss as sink, supply loss or enable high.
// - No main supply: Rd on both CC lines, act as sink.
// - Supply present and enable high: shutdown, Rd kept on CC.
// - Unattached states follow port configuration, dual-role toggles.
// - Attached states follow port configuration, accessories allowed in all.
package tcpc_pkg;

	localparam int CLK_MHZ        = 250;
	localparam int TOGGLE_US      = 50;
	localparam int TOGGLE_CYCLES  = TOGGLE_US * CLK_MHZ;
	localparam int DEBOUNCE_US    = 100;
	localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;
	localparam logic [6:0] ADDR_BASE = 7'h47;
	localparam int ADDR_SEL_BIT   = 6;

	// Three-level pin level as reported by the pad comparator
	typedef enum logic [1:0] {
		TCPC_LVL_LOW   = 2'b00,
		TCPC_LVL_HIGH  = 2'b01,
		TCPC_LVL_FLOAT = 2'b10
	} tcpc_level_type;

	typedef enum logic [1:0] {
		TCPC_PORT_UFP = 2'b00,
		TCPC_PORT_DFP = 2'b01,
		TCPC_PORT_DRP = 2'b10
	} tcpc_port_type;

	typedef enum logic [1:0] {
		TCPC_CUR_DEFAULT = 2'b00,
		TCPC_CUR_MID     = 2'b01,
		TCPC_CUR_HIGH    = 2'b10
	} tcpc_cur_type;

	typedef enum logic [3:0] {
		TCPC_ST_SHUTDOWN   = 4'h0,
		TCPC_ST_UNATT_SNK  = 4'h1,
		TCPC_ST_UNATT_SRC  = 4'h2,
		TCPC_ST_WAIT_SNK   = 4'h3,
		TCPC_ST_WAIT_SRC   = 4'h4,
		TCPC_ST_ATT_SNK    = 4'h5,
		TCPC_ST_ATT_SRC    = 4'h6,
		TCPC_ST_AUDIO      = 4'h7,
		TCPC_ST_DEBUG      = 4'h8
	} tcpc_state_type;

	// CC front-end view, already decoded per orientation
	typedef struct packed {
		logic        rd_seen;      // Sink termination on one CC
		logic        ra_other;     // Ra on the unused CC
		logic        rp_seen;      // Source pull-up on one CC
		tcpc_cur_type rp_cur;      // Advertised current seen as sink
		logic        ra_both;      // Audio accessory
		logic        rd_both;      // Debug accessory as source
		logic        rp_both;      // Debug accessory as sink
	} tcpc_cc_type;

	// Status bits the register side reads
	typedef struct packed {
		tcpc_state_type state;
		logic           vconn_on;
		logic           vconn_fault;
		logic           int_pending;
		tcpc_cur_type   cur_detect;
	} tcpc_status_type;

endpackage

// ---- rtl/tcpc_tick.sv ----
// Cycle divider producing a one-cycle enable pulse.
// Assumes the single system clock; restart resynchronises the period.
`timescale 1ns/1ps
`default_nettype none
module tcpc_tick #(
	parameter int CYCLES = 12500
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	// Control
	input  wire logic restart,
	output logic      tick
);
	localparam int W = $clog2(CYCLES + 1);
	logic [W-1:0] cnt_r;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
		end else if (restart || tick) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + W'(1);
		end
	end

	assign tick = (cnt_r == W'(CYCLES - 1));
endmodule
`default_nettype wire

// ---- rtl/tcpc_port_ctrl.sv ----
// Port mode, role state machine, VCONN switch and status pins.
// Assumes CC detection happens in the analog front end (debounce is timed here) and
// that the register block decodes host writes into clear pulses.
`timescale 1ns/1ps
`default_nettype none
module tcpc_port_ctrl #(
	parameter int TOGGLE_CYCLES   = tcpc_pkg::TOGGLE_CYCLES,
	parameter int DEBOUNCE_CYCLES = tcpc_pkg::DEBOUNCE_CYCLES
) (
	// Clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     rst_n,
	// Supply, enable and straps
	input  wire logic                     main_supply_5v,
	input  wire logic                     cc_enable_n,
	input  wire tcpc_pkg::tcpc_level_type addr_sel_level,
	input  wire tcpc_pkg::tcpc_port_type  port_cfg,
	// Port partner side
	input  wire tcpc_pkg::tcpc_cc_type    cc_in,
	input  wire logic                     bus_power_sense_in,
	input  wire logic                     vconn_overcurrent,
	// Host register side
	input  wire logic                     vconn_fault_clr,
	input  wire logic                     int_status_clr,
	// CC terminations and VCONN switch
	output logic                          cc_rd_en,
	output logic                          cc_rp_en,
	output logic                          vconn_switch_on,
	// Mode and address
	output logic                          i2c_mode,
	output logic [6:0]                    i2c_target_addr,
	// Open-drain pins, enable high while pulled low
	output logic                          attach_as_source_out_oe,
	output logic                          current_status_out_a_oe,
	output logic                          current_status_out_b_oe,
	output logic                          int_audio_out_oe,
	// Status
	output tcpc_pkg::tcpc_status_type     status
);
	tcpc_pkg::tcpc_state_type st_r, st_nxt;
	tcpc_pkg::tcpc_port_type  port_r;
	logic                     strap_done_r;
	logic                     i2c_mode_r;
	logic [6:0]               addr_r;
	logic                     vconn_r;
	logic                     fault_r;
	logic                     gpio_lock_r;
	logic                     int_pend_r;
	logic                     int_oe_r;
	logic                     cur_a_r;
	logic                     cur_b_r;
	logic                     id_r;
	tcpc_pkg::tcpc_cur_type   cur_det_r;
	logic                     powered;
	logic                     attached;
	logic                     toggle_tick;
	logic                     deb_tick;
	logic                     st_change;

	// Supply and enable gate all operation
	assign powered = main_supply_5v && !cc_enable_n;

	// Straps are caught once after release, never by the reset itself
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_done_r <= 1'b0;
			i2c_mode_r   <= 1'b0;
			addr_r       <= tcpc_pkg::ADDR_BASE;
			port_r       <= tcpc_pkg::TCPC_PORT_DRP;
		end else if (!strap_done_r && powered) begin
			strap_done_r <= 1'b1;
			i2c_mode_r   <= (addr_sel_level != tcpc_pkg::TCPC_LVL_FLOAT);
			addr_r       <= tcpc_pkg::ADDR_BASE;
			addr_r[tcpc_pkg::ADDR_SEL_BIT] <= (addr_sel_level == tcpc_pkg::TCPC_LVL_HIGH);
			port_r       <= port_cfg;
		end
	end

	tcpc_tick #(
		.CYCLES (TOGGLE_CYCLES)
	) u_toggle (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.restart (st_change),
		.tick    (toggle_tick)
	);

	tcpc_tick #(
		.CYCLES (DEBOUNCE_CYCLES)
	) u_debounce (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.restart (st_change),
		.tick    (deb_tick)
	);

	// Any state move restarts both timers
	assign st_change = (st_nxt != st_r);
	assign attached  = (st_r == tcpc_pkg::TCPC_ST_ATT_SNK) || (st_r == tcpc_pkg::TCPC_ST_ATT_SRC) ||
		(st_r == tcpc_pkg::TCPC_ST_AUDIO) || (st_r == tcpc_pkg::TCPC_ST_DEBUG);

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			tcpc_pkg::TCPC_ST_SHUTDOWN: begin
				if (powered && strap_done_r) begin
					st_nxt = tcpc_pkg::TCPC_ST_UNATT_SNK;
				end
			end
			tcpc_pkg::TCPC_ST_UNATT_SNK: begin
				if (port_r == tcpc_pkg::TCPC_PORT_DFP) begin
					st_nxt = tcpc_pkg::TCPC_ST_UNATT_SRC;
				end else if (cc_in.rp_seen || cc_in.rp_both || cc_in.ra_both) begin
					// Accessories are sought from the sink side too
					st_nxt = tcpc_pkg::TCPC_ST_WAIT_SNK;
				end else if (port_r == tcpc_pkg::TCPC_PORT_DRP && toggle_tick) begin
					st_nxt = tcpc_pkg::TCPC_ST_UNATT_SRC;
				end
			end
			tcpc_pkg::TCPC_ST_UNATT_SRC: begin
				if (cc_in.rd_seen || cc_in.ra_both || cc_in.rd_both) begin
					st_nxt = tcpc_pkg::TCPC_ST_WAIT_SRC;
				end else if (port_r == tcpc_pkg::TCPC_PORT_DRP && toggle_tick) begin
					st_nxt = tcpc_pkg::TCPC_ST_UNATT_SNK;
				end
			end
			tcpc_pkg::TCPC_ST_WAIT_SNK: begin
				if (!cc_in.rp_seen && !cc_in.rp_both && !cc_in.ra_both) begin
					st_nxt = tcpc_pkg::TCPC_ST_UNATT_SNK;
				end else if (deb_tick && cc_in.ra_both) begin
					// Passive audio adapter supplies no VBUS, so none is awaited
					st_nxt = tcpc_pkg::TCPC_ST_AUDIO;
				end else if (deb_tick && bus_power_sense_in) begin
					st_nxt = cc_in.rp_both ? tcpc_pkg::TCPC_ST_DEBUG
						: tcpc_pkg::TCPC_ST_ATT_SNK;
				end
			end
			tcpc_pkg::TCPC_ST_WAIT_SRC: begin
				if (!cc_in.rd_seen && !cc_in.ra_both && !cc_in.rd_both) begin
					st_nxt = tcpc_pkg::TCPC_ST_UNATT_SRC;
				end else if (deb_tick && !bus_power_sense_in) begin
					// VBUS must be low before taking the source role
					if (cc_in.ra_both) begin
						st_nxt = tcpc_pkg::TCPC_ST_AUDIO;
					end else if (cc_in.rd_both) begin
						st_nxt = tcpc_pkg::TCPC_ST_DEBUG;
					end else begin
						st_nxt = tcpc_pkg::TCPC_ST_ATT_SRC;
					end
				end
			end
			tcpc_pkg::TCPC_ST_ATT_SNK: begin
				if (!bus_power_sense_in) begin
					st_nxt = tcpc_pkg::TCPC_ST_UNATT_SNK;
				end
			end
			tcpc_pkg::TCPC_ST_ATT_SRC: begin
				if (!cc_in.rd_seen) begin
					st_nxt = tcpc_pkg::TCPC_ST_UNATT_SNK;
				end
			end
			tcpc_pkg::TCPC_ST_AUDIO: begin
				if (!cc_in.ra_both) begin
					st_nxt = tcpc_pkg::TCPC_ST_UNATT_SNK;
				end
			end
			tcpc_pkg::TCPC_ST_DEBUG: begin
				if (!cc_in.rd_both && !(cc_in.rp_both && bus_power_sense_in)) begin
					st_nxt = tcpc_pkg::TCPC_ST_UNATT_SNK;
				end
			end
			default: begin
				st_nxt = tcpc_pkg::TCPC_ST_SHUTDOWN;
			end
		endcase
		// Supply or enable loss overrides every state
		if (!powered) begin
			st_nxt = tcpc_pkg::TCPC_ST_SHUTDOWN;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= tcpc_pkg::TCPC_ST_SHUTDOWN;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Rd unless presenting as a source; also default when unpowered
	assign cc_rp_en = powered && ((st_r == tcpc_pkg::TCPC_ST_UNATT_SRC) ||
		(st_r == tcpc_pkg::TCPC_ST_WAIT_SRC) || (st_r == tcpc_pkg::TCPC_ST_ATT_SRC) ||
		(st_r == tcpc_pkg::TCPC_ST_AUDIO) ||
		(st_r == tcpc_pkg::TCPC_ST_DEBUG && cc_in.rd_both));
	assign cc_rd_en = !cc_rp_en;

	// Fault flag: overcurrent wins over a same-cycle clear
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_r <= 1'b0;
		end else if (vconn_r && vconn_overcurrent && i2c_mode_r) begin
			fault_r <= 1'b1;
		end else if (vconn_fault_clr) begin
			fault_r <= 1'b0;
		end
	end

	// Pin control lockout held until the port detaches
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			gpio_lock_r <= 1'b0;
		end else if (vconn_r && vconn_overcurrent && !i2c_mode_r) begin
			gpio_lock_r <= 1'b1;
		end else if (st_r != tcpc_pkg::TCPC_ST_ATT_SRC) begin
			gpio_lock_r <= 1'b0;
		end
	end

	// From the next state, so VCONN and the attached state move together
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			vconn_r <= 1'b0;
		end else begin
			vconn_r <= (st_nxt == tcpc_pkg::TCPC_ST_ATT_SRC) && cc_in.ra_other &&
				!fault_r && !gpio_lock_r && !vconn_overcurrent &&
				(port_r != tcpc_pkg::TCPC_PORT_UFP) && powered;
		end
	end

	// Status-change event drives the interrupt in host control
	logic status_evt;
	assign status_evt = st_change || (vconn_r && vconn_overcurrent && i2c_mode_r);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			int_pend_r <= 1'b0;
		end else if (status_evt && i2c_mode_r && powered) begin
			int_pend_r <= 1'b1;
		end else if (int_status_clr) begin
			int_pend_r <= 1'b0;
		end
	end

	// Detected current kept only while attached as a sink
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_det_r <= tcpc_pkg::TCPC_CUR_DEFAULT;
		end else if (st_r == tcpc_pkg::TCPC_ST_ATT_SNK) begin
			cur_det_r <= cc_in.rp_cur;
		end else if (!attached) begin
			cur_det_r <= tcpc_pkg::TCPC_CUR_DEFAULT;
		end
	end

	// Pin outputs registered; oe high means pulled low
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			id_r <= 1'b0;
		end else begin
			id_r <= powered && (st_r == tcpc_pkg::TCPC_ST_ATT_SRC);
		end
	end

	// Current pins only meaningful while attached as a sink in pin control
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_a_r <= 1'b0;
			cur_b_r <= 1'b0;
		end else if (!i2c_mode_r && powered && st_r == tcpc_pkg::TCPC_ST_ATT_SNK) begin
			cur_a_r <= (cur_det_r != tcpc_pkg::TCPC_CUR_DEFAULT);
			cur_b_r <= (cur_det_r == tcpc_pkg::TCPC_CUR_HIGH);
		end else begin
			cur_a_r <= 1'b0;
			cur_b_r <= 1'b0;
		end
	end

	// Shared pin: interrupt in host control, audio flag in pin control
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			int_oe_r <= 1'b0;
		end else if (i2c_mode_r) begin
			int_oe_r <= powered && int_pend_r;
		end else begin
			int_oe_r <= powered && (st_r == tcpc_pkg::TCPC_ST_AUDIO);
		end
	end

	assign vconn_switch_on         = vconn_r;
	assign i2c_mode                = i2c_mode_r;
	assign i2c_target_addr         = addr_r;
	assign attach_as_source_out_oe = id_r;
	assign current_status_out_a_oe = cur_a_r;
	assign current_status_out_b_oe = cur_b_r;
	assign int_audio_out_oe        = int_oe_r;
	assign status.state            = st_r;
	assign status.vconn_on         = vconn_r;
	assign status.vconn_fault      = fault_r;
	assign status.int_pending      = int_pend_r;
	assign status.cur_detect       = cur_det_r;
endmodule
`default_nettype wire

// ---- tb/tcpc_port_ctrl_monitor.sv ----
// Checker for the port mode and VCONN control block, bound to its top.
// Assumes straps are held steady and change only under reset.
`timescale 1ns/1ps
`default_nettype none
module tcpc_port_ctrl_monitor #(
	parameter int TOGGLE_CYCLES   = 8,
	parameter int DEBOUNCE_CYCLES = 16
) (
	// Inputs of the block
	input wire logic                      sys_clk,
	input wire logic                      rst_n,
	input wire tcpc_pkg::tcpc_level_type  addr_sel_level,
	input wire tcpc_pkg::tcpc_cc_type     cc_in,
	input wire logic                      vconn_overcurrent,
	input wire logic                      int_status_clr,
	// Outputs of the block
	input wire logic                      vconn_switch_on,
	input wire logic                      i2c_mode,
	input wire logic [6:0]                i2c_target_addr,
	input wire logic                      attach_as_source_out_oe,
	input wire logic                      current_status_out_a_oe,
	input wire logic                      current_status_out_b_oe,
	input wire logic                      int_audio_out_oe,
	input wire tcpc_pkg::tcpc_status_type status
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	property p_vc_start;
		$rose(vconn_switch_on) |-> status.state == tcpc_pkg::TCPC_ST_ATT_SRC
			&& $past(cc_in.ra_other);
	endproperty
	a_vc_start: assert property (p_vc_start) else $error("vconn start");
	property p_vc_src;
		vconn_switch_on |-> status.state == tcpc_pkg::TCPC_ST_ATT_SRC;
	endproperty
	a_vc_src: assert property (p_vc_src) else $error("vconn outside source");
	property p_oc;
		vconn_switch_on && vconn_overcurrent |=> !vconn_switch_on
			&& (status.vconn_fault || !i2c_mode);
	endproperty
	a_oc: assert property (p_oc) else $error("overcurrent ignored");
	property p_addr;
		i2c_mode |-> i2c_target_addr == {addr_sel_level == tcpc_pkg::TCPC_LVL_HIGH, 6'h07};
	endproperty
	a_addr: assert property (p_addr) else $error("target address");
	property p_cur;
		!i2c_mode && status.state == tcpc_pkg::TCPC_ST_ATT_SNK ##1 $stable(status)
			|-> current_status_out_a_oe == (status.cur_detect != tcpc_pkg::TCPC_CUR_DEFAULT)
			&& current_status_out_b_oe == (status.cur_detect == tcpc_pkg::TCPC_CUR_HIGH);
	endproperty
	a_cur: assert property (p_cur) else $error("current pins");
	property p_audio;
		!i2c_mode && status.state == tcpc_pkg::TCPC_ST_AUDIO [*2] |-> int_audio_out_oe;
	endproperty
	a_audio: assert property (p_audio) else $error("audio pin");
	property p_int;
		i2c_mode && $changed(status.state) |=> status.int_pending ##1 int_audio_out_oe;
	endproperty
	a_int: assert property (p_int) else $error("interrupt missing");
	property p_rel;
		i2c_mode && int_status_clr && !vconn_overcurrent ##1 $stable(status.state)
			|-> !status.int_pending ##1 !int_audio_out_oe;
	endproperty
	a_rel: assert property (p_rel) else $error("interrupt kept");
	property p_id;
		attach_as_source_out_oe == ($past(status.state) == tcpc_pkg::TCPC_ST_ATT_SRC);
	endproperty
	a_id: assert property (p_id) else $error("source pin");
endmodule

bind tcpc_port_ctrl tcpc_port_ctrl_monitor #(.TOGGLE_CYCLES(TOGGLE_CYCLES),
	.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) tcpc_port_ctrl_monitor_i (.sys_clk, .rst_n,
	.addr_sel_level, .cc_in, .vconn_overcurrent, .int_status_clr, .vconn_switch_on,
	.i2c_mode, .i2c_target_addr, .attach_as_source_out_oe, .current_status_out_a_oe,
	.current_status_out_b_oe, .int_audio_out_oe, .status);
`default_nettype wire

// ---- tb/tcpc_partner_model.sv ----
// Far side on CC and VBUS: nothing, sink, sink with cable, source, audio or debug.
// Assumes the bench selects what is plugged in.
`timescale 1ns/1ps
`default_nettype none
module tcpc_partner_model (
	// Bench control: 0 none, 1 sink, 2 sink with cable, 3 source, 4 audio, 5 debug
	input wire logic [2:0]             kind,
	input wire tcpc_pkg::tcpc_cur_type cur,
	input wire logic                   dut_rp,
	// Toward the block
	output var tcpc_pkg::tcpc_cc_type  cc,
	output var logic                   vbus
);
	// Rd on one CC is only seen while we pull up, Rp only while we pull down; accessories are seen always
	always_comb begin
		cc = '0;
		cc.rd_seen = (kind == 3'h1 || kind == 3'h2) && dut_rp;
		cc.ra_other = kind == 3'h2 && dut_rp;
		cc.rp_seen = kind == 3'h3 && !dut_rp;
		cc.rp_cur = cur;
		cc.ra_both = kind == 3'h4;
		cc.rd_both = kind == 3'h5;
		vbus = kind == 3'h3;
	end
endmodule
`default_nettype wire

// ---- tb/tb_tcpc_port_ctrl.sv ----
// Self-checking bench for the port mode and VCONN control block.
// Assumes the partner model on CC and VBUS; straps change only under reset.
`timescale 1ns/1ps
`default_nettype none
module tb_tcpc_port_ctrl;
	logic                      sys_clk, rst_n, main_supply_5v, cc_enable_n, cc_rd_en, cc_rp_en;
	logic                      vconn_overcurrent, vconn_fault_clr, int_status_clr, i2c_mode;
	logic                      vconn_switch_on, attach_as_source_out_oe, int_audio_out_oe;
	logic                      current_status_out_a_oe, current_status_out_b_oe, vbus;
	logic [6:0]                i2c_target_addr;
	logic [2:0]                kind;
	logic [31:0]               seed;
	tcpc_pkg::tcpc_level_type  lvl;
	tcpc_pkg::tcpc_port_type   port_cfg;
	tcpc_pkg::tcpc_cc_type     cc_in;
	tcpc_pkg::tcpc_cur_type    cur;
	tcpc_pkg::tcpc_status_type status;
	int                        miscompares = 0, num_checks = 0, cyc = 0;

	tcpc_port_ctrl #(.TOGGLE_CYCLES(8), .DEBOUNCE_CYCLES(16)) tcpc_port_ctrl_i (.sys_clk, .rst_n,
		.main_supply_5v, .cc_enable_n, .addr_sel_level(lvl), .port_cfg, .cc_in,
		.bus_power_sense_in(vbus), .vconn_overcurrent, .vconn_fault_clr, .int_status_clr,
		.cc_rd_en, .cc_rp_en, .vconn_switch_on, .i2c_mode, .i2c_target_addr,
		.attach_as_source_out_oe, .current_status_out_a_oe, .current_status_out_b_oe,
		.int_audio_out_oe, .status);
	tcpc_partner_model tcpc_partner_model_i (.kind, .cur, .dut_rp(cc_rp_en), .cc(cc_in), .vbus);

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// Whole run needs a few hundred cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			conclude();
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction

	function automatic logic [6:0] exp_pins(input tcpc_pkg::tcpc_cur_type c);
		return {5'h00, c != tcpc_pkg::TCPC_CUR_DEFAULT, c == tcpc_pkg::TCPC_CUR_HIGH};
	endfunction

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [6:0] got, input logic [6:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wait_st(input tcpc_pkg::tcpc_state_type s);
		int n;
		n = 0;
		while (status.state !== s && n < 400) begin
			@(negedge sys_clk);
			n++;
		end
		chk(7'(status.state), 7'(s));
	endtask

	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge sys_clk);
		s = 1'b0;
		@(negedge sys_clk);
	endtask

	task automatic start(input tcpc_pkg::tcpc_level_type l, input tcpc_pkg::tcpc_port_type p);
		rst_n = 1'b0;
		lvl = l;
		port_cfg = p;
		kind = 3'h0;
		main_supply_5v = 1'b1;
		cc_enable_n = 1'b0;
		repeat (10) @(negedge sys_clk);
		rst_n = 1'b1;
		wait_st(tcpc_pkg::TCPC_ST_UNATT_SNK);
		chk(7'(i2c_mode), 7'(l != tcpc_pkg::TCPC_LVL_FLOAT));
		if (i2c_mode)
			chk(i2c_target_addr, {l == tcpc_pkg::TCPC_LVL_HIGH, 6'h07});
	endtask

	initial begin
		{vconn_overcurrent, vconn_fault_clr, int_status_clr} = 3'h0;
		seed = 32'hC3B0;
		cur = tcpc_pkg::TCPC_CUR_DEFAULT;
		start(tcpc_pkg::TCPC_LVL_FLOAT, tcpc_pkg::TCPC_PORT_UFP);
		// Every current code first, then random ones
		for (int i = 0; i < 5; i++) begin
			seed = xs(seed);
			cur = tcpc_pkg::tcpc_cur_type'(i < 3 ? i : int'(seed % 3));
			kind = 3'h3;
			wait_st(tcpc_pkg::TCPC_ST_ATT_SNK);
			repeat (2) @(negedge sys_clk);
			chk({5'h00, current_status_out_a_oe, current_status_out_b_oe}, exp_pins(cur));
			kind = 3'h0;
			wait_st(tcpc_pkg::TCPC_ST_UNATT_SNK);
		end
		kind = 3'h4;
		wait_st(tcpc_pkg::TCPC_ST_AUDIO);
		repeat (2) @(negedge sys_clk);
		chk(7'(int_audio_out_oe), 7'h1);
		kind = 3'h0;
		cc_enable_n = 1'b1;
		wait_st(tcpc_pkg::TCPC_ST_SHUTDOWN);
		chk(7'(cc_rd_en), 7'h1);
		cc_enable_n = 1'b0;
		wait_st(tcpc_pkg::TCPC_ST_UNATT_SNK);
		main_supply_5v = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk({5'h00, cc_rd_en, vconn_switch_on}, 7'h2);
		$display("test gpio sink done");
		start(tcpc_pkg::TCPC_LVL_HIGH, tcpc_pkg::TCPC_PORT_DFP);
		kind = 3'h2;
		wait_st(tcpc_pkg::TCPC_ST_ATT_SRC);
		@(negedge sys_clk);
		chk({4'h0, vconn_switch_on, attach_as_source_out_oe, status.int_pending}, 7'h7);
		pulse(int_status_clr);
		chk({5'h00, status.int_pending, int_audio_out_oe}, 7'h0);
		pulse(vconn_overcurrent);
		chk({5'h00, vconn_switch_on, status.vconn_fault}, 7'h1);
		chk({5'h00, status.int_pending, int_audio_out_oe}, 7'h3);
		pulse(vconn_fault_clr);
		chk(7'(status.vconn_fault), 7'h0);
		chk(7'(vconn_switch_on), 7'h1);
		kind = 3'h0;
		wait_st(tcpc_pkg::TCPC_ST_UNATT_SRC);
		chk(7'(vconn_switch_on), 7'h0);
		$display("test host source done");
		start(tcpc_pkg::TCPC_LVL_LOW, tcpc_pkg::TCPC_PORT_DRP);
		wait_st(tcpc_pkg::TCPC_ST_UNATT_SRC);
		wait_st(tcpc_pkg::TCPC_ST_UNATT_SNK);
		kind = 3'h1;
		wait_st(tcpc_pkg::TCPC_ST_ATT_SRC);
		@(negedge sys_clk);
		chk(7'(vconn_switch_on), 7'h0);
		$display("test dual role done");
		start(tcpc_pkg::TCPC_LVL_FLOAT, tcpc_pkg::TCPC_PORT_DFP);
		for (int i = 0; i < 2; i++) begin
			kind = 3'h2;
			wait_st(tcpc_pkg::TCPC_ST_ATT_SRC);
			@(negedge sys_clk);
			chk(7'(vconn_switch_on), 7'h1);
			pulse(vconn_overcurrent);
			pulse(vconn_fault_clr);
			chk(7'(vconn_switch_on), 7'h0);
			kind = 3'h0;
			wait_st(tcpc_pkg::TCPC_ST_UNATT_SRC);
		end
		kind = 3'h5;
		wait_st(tcpc_pkg::TCPC_ST_DEBUG);
		chk({5'h00, vconn_switch_on, attach_as_source_out_oe}, 7'h0);
		$display("test gpio lock done");
		conclude();
	end
endmodule
`default_nettype wire
